// File: verilog/segment_attr_cfg.svh
// constants for the legacy segment attribute router
`ifndef SEGMENT_ATTR_CFG_SVH
`define SEGMENT_ATTR_CFG_SVH
// register indices; byte address is four times the index
`define ATTR_IDX_FIRST  8'h59
`define ATTR_IDX_LAST   8'h5f
`define ATTR_REG_COUNT  7
`define ATTR_RESET      8'h00
// writable bits: whole low field of the first register and bits 7,3 are reserved
`define ATTR_MASK_FIRST 8'h70
`define ATTR_MASK       8'h77
// field layout
`define FLD_WIDTH       4
`define FLD_RD          0
`define FLD_WR          1
`define FLD_CE          2
`define FLD_COUNT       14
// address decode: 16 Kbyte blocks and the 64 Kbyte system bios area
`define BIOS_BLK64      4'hf
`define EXP_BLK_FIRST   6'h30
`define EXP_BLK_LAST    6'h3b
`define EXP_FLD_FIRST   4'h2
`define BIOS_FLD        4'h1
// axi responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// File: verilog/segment_attr_pkg.sv
// types shared by the legacy segment attribute router
package segment_attr_pkg;
  typedef enum logic [1:0] {
    seg_disabled,
    seg_read_only,
    seg_write_only,
    seg_read_write
  } seg_state_t;
endpackage : segment_attr_pkg

// File: verilog/legacy_segment_attribute_router.sv
// legacy segment attribute router: attribute registers, cpu routing and pci claim
//
// What this block does
// R01: programmable routing and cacheability for thirteen segments between 640K and 1M.
// R02: seven 8-bit read/write attribute registers at indices 59h through 5Fh.
// R03: each segment has a read bit, a write bit and a cacheability bit.
// R04: read bit 1 sends cpu reads to memory, 0 sends them to pci.
// R05: write bit 1 sends cpu writes to memory, 0 sends them to pci.
// R06: cacheability bit 1 marks the segment first-level cacheable.
// R07: software never sets cacheability while the read bit is zero.
// R08: cacheable but not writable segments are cached only on code reads.
// R09: read-only segments serve cpu reads from memory or second-level cache.
// R10: read-only segments send cpu writes to pci, memory ignores them.
// R11: read-only segments are never allocated in the second-level cache.
// R12: write-only segments send cpu reads to pci, memory ignores them.
// R13: write-only segments serve cpu writes from memory normally.
// R14: read/write segments serve reads and writes from cpu and pci.
// R15: disabled segments send every cpu access to pci.
// R16: two 4-bit fields per register: reserved, cache, write, read from top.
// R17: pci masters are claimed only for writable writes and readable reads.
// R18: first low field reserved, high field bios; rest ascend from 0C0000h.
// R19: software keeps cacheability bits still while second-level cache is on.
// R20: after reset every segment is disabled and non-cacheable.
// R21: accesses outside the governed segments are not affected.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "segment_attr_cfg.svh"

module legacy_segment_attribute_router
  import segment_attr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // axi4-lite slave
  input  wire logic              awvalid_in,
  input  wire logic [ADDR_W-1:0] awaddr_in,
  output logic                   awready_out,
  input  wire logic              wvalid_in,
  input  wire logic [31:0]       wdata_in,
  input  wire logic [3:0]        wstrb_in,
  output logic                   wready_out,
  output logic                   bvalid_out,
  output logic [1:0]             bresp_out,
  input  wire logic              bready_in,
  input  wire logic              arvalid_in,
  input  wire logic [ADDR_W-1:0] araddr_in,
  output logic                   arready_out,
  output logic                   rvalid_out,
  output logic [31:0]            rdata_out,
  output logic [1:0]             rresp_out,
  input  wire logic              rready_in,
  // cpu cycle decoder side
  input  wire logic              cpu_req_in,
  input  wire logic [31:0]       cpu_addr_in,
  input  wire logic              cpu_write_in,
  input  wire logic              cpu_code_in,
  output logic                   cpu_valid_out,
  output logic                   cpu_in_range_out,
  output logic                   cpu_to_dram_out,
  output logic                   cpu_to_pci_out,
  output logic                   cpu_l1_cacheable_out,
  output logic                   cpu_l2_alloc_out,
  output seg_state_t             cpu_state_out,
  // pci master access side
  input  wire logic              pci_req_in,
  input  wire logic [31:0]       pci_addr_in,
  input  wire logic              pci_write_in,
  output logic                   pci_valid_out,
  output logic                   pci_claim_out
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0]              attribute_map [`ATTR_REG_COUNT];
  logic [7:0]              next_attribute_map [`ATTR_REG_COUNT];
  logic [`FLD_WIDTH-1:0]   field_attr [`FLD_COUNT];
  logic                    aw_held, next_aw_held;
  logic                    w_held, next_w_held;
  logic [ADDR_W-1:0]       aw_addr, next_aw_addr;
  logic [7:0]              w_byte, next_w_byte;
  logic                    w_lane, next_w_lane;
  logic                    next_awready, next_wready;
  logic                    next_bvalid;
  logic [1:0]              next_bresp;
  logic                    next_arready, next_rvalid;
  logic [31:0]             next_rdata;
  logic [1:0]              next_rresp;
  logic [3:0]              cpu_fld, pci_fld;
  logic                    cpu_hit, pci_hit;
  logic [`FLD_WIDTH-1:0]   cpu_attr, pci_attr;
  logic                    next_cpu_valid, next_in_range;
  logic                    next_to_dram, next_to_pci;
  logic                    next_l1, next_l2;
  seg_state_t              next_state;
  logic                    next_pci_valid, next_pci_claim;

  // ************************************************************
  // helpers
  // ************************************************************
  // register index behind a word address; count means unmapped
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    reg_index = 3'(`ATTR_REG_COUNT);
    if (a[ADDR_W-1:10] == '0 && idx >= `ATTR_IDX_FIRST && idx <= `ATTR_IDX_LAST) begin
      reg_index = 3'(idx - `ATTR_IDX_FIRST);
    end
  endfunction : reg_index

  // field governing an address; zero means outside the governed range
  function automatic logic [3:0] seg_field(input logic [31:0] a);
    seg_field = 4'h0;
    if (a[31:20] == 12'h000) begin
      if (a[19:16] == `BIOS_BLK64) begin
        seg_field = `BIOS_FLD; // [R18]
      end else if (a[19:14] >= `EXP_BLK_FIRST && a[19:14] <= `EXP_BLK_LAST) begin
        seg_field = 4'(a[19:14] - `EXP_BLK_FIRST) + `EXP_FLD_FIRST; // [R18]
      end
    end
  endfunction : seg_field

  // ************************************************************
  // field extraction
  // ************************************************************
  // fields pair up low then high within each register
  for (genvar f = 0; f < `FLD_COUNT; f++) begin : g_field
    assign field_attr[f] = attribute_map[f/2][`FLD_WIDTH*(f%2) +: `FLD_WIDTH]; // [R16]
  end

  // ************************************************************
  // axi4-lite register slave
  // ************************************************************
  // address and data are held separately so either may arrive first;
  // the commit waits one cycle for both, costing latency but no mux on the bus
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = bvalid_out;
    next_bresp   = bresp_out;
    for (int i = 0; i < `ATTR_REG_COUNT; i++) begin
      next_attribute_map[i] = attribute_map[i];
    end
    if (awvalid_in && awready_out) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      next_w_held = 1'b1;
      next_w_byte = wdata_in[7:0];
      next_w_lane = wstrb_in[0];
    end
    if (bvalid_out && bready_in) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid_out) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (reg_index(aw_addr) < 3'(`ATTR_REG_COUNT)) begin
        next_bresp = `RESP_OKAY;
        if (w_lane) begin
          next_attribute_map[reg_index(aw_addr)] = w_byte &
            ((reg_index(aw_addr) == 3'h0) ? `ATTR_MASK_FIRST : `ATTR_MASK); // [R02] [R16]
        end
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  always_comb begin
    next_arready = arready_out;
    next_rvalid  = rvalid_out;
    next_rdata   = rdata_out;
    next_rresp   = rresp_out;
    if (rvalid_out && rready_in) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid_in && arready_out) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rdata   = 32'h0000_0000;
      next_rresp   = `RESP_SLVERR;
      if (reg_index(araddr_in) < 3'(`ATTR_REG_COUNT)) begin
        next_rdata = {24'h00_0000, attribute_map[reg_index(araddr_in)]}; // [R02]
        next_rresp = `RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `ATTR_REG_COUNT; i++) begin
        attribute_map[i] <= `ATTR_RESET; // [R20]
      end
      aw_held     <= 1'b0;
      aw_addr     <= '0;
      w_held      <= 1'b0;
      w_byte      <= 8'h00;
      w_lane      <= 1'b0;
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      bvalid_out  <= 1'b0;
      bresp_out   <= `RESP_OKAY;
      arready_out <= 1'b1;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0000_0000;
      rresp_out   <= `RESP_OKAY;
    end else begin
      for (int i = 0; i < `ATTR_REG_COUNT; i++) begin
        attribute_map[i] <= next_attribute_map[i];
      end
      aw_held     <= next_aw_held;
      aw_addr     <= next_aw_addr;
      w_held      <= next_w_held;
      w_byte      <= next_w_byte;
      w_lane      <= next_w_lane;
      awready_out <= next_awready;
      wready_out  <= next_wready;
      bvalid_out  <= next_bvalid;
      bresp_out   <= next_bresp;
      arready_out <= next_arready;
      rvalid_out  <= next_rvalid;
      rdata_out   <= next_rdata;
      rresp_out   <= next_rresp;
    end
  end

  // ************************************************************
  // cpu and pci routing decision
  // ************************************************************
  // the cacheability bit is gated by the read bit; software keeps it consistent
  // with the read bit and leaves it alone while the l2 cache is on [R07] [R19]
  always_comb begin
    cpu_fld  = seg_field(cpu_addr_in);
    cpu_hit  = (cpu_fld != 4'h0); // [R01] [R21]
    cpu_attr = field_attr[cpu_fld];
    pci_fld  = seg_field(pci_addr_in);
    pci_hit  = (pci_fld != 4'h0);
    pci_attr = field_attr[pci_fld];
    next_cpu_valid = cpu_req_in;
    next_in_range  = cpu_req_in && cpu_hit;
    // reads follow the read bit, writes the write bit [R03] [R04] [R05]
    next_to_dram = next_in_range &&
      (cpu_write_in ? cpu_attr[`FLD_WR] : cpu_attr[`FLD_RD]); // [R09] [R13] [R14]
    next_to_pci  = next_in_range && !next_to_dram; // [R10] [R12] [R15]
    next_l1 = next_in_range && !cpu_write_in && cpu_attr[`FLD_CE] &&
      cpu_attr[`FLD_RD] && (cpu_attr[`FLD_WR] || cpu_code_in); // [R06] [R08]
    next_l2 = next_in_range && cpu_attr[`FLD_RD] && cpu_attr[`FLD_WR]; // [R11]
    next_state = seg_disabled; // [R15] [R20]
    if (next_in_range) begin
      next_state = seg_state_t'({cpu_attr[`FLD_WR], cpu_attr[`FLD_RD]});
    end
    next_pci_valid = pci_req_in;
    next_pci_claim = pci_req_in && pci_hit &&
      (pci_write_in ? pci_attr[`FLD_WR] : pci_attr[`FLD_RD]); // [R17] [R14]
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_valid_out        <= 1'b0;
      cpu_in_range_out     <= 1'b0;
      cpu_to_dram_out      <= 1'b0;
      cpu_to_pci_out       <= 1'b0;
      cpu_l1_cacheable_out <= 1'b0;
      cpu_l2_alloc_out     <= 1'b0;
      cpu_state_out        <= seg_disabled;
      pci_valid_out        <= 1'b0;
      pci_claim_out        <= 1'b0;
    end else begin
      cpu_valid_out        <= next_cpu_valid;
      cpu_in_range_out     <= next_in_range;
      cpu_to_dram_out      <= next_to_dram;
      cpu_to_pci_out       <= next_to_pci;
      cpu_l1_cacheable_out <= next_l1;
      cpu_l2_alloc_out     <= next_l2;
      cpu_state_out        <= next_state;
      pci_valid_out        <= next_pci_valid;
      pci_claim_out        <= next_pci_claim;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  rd_route_a: assert property ( // [R04]
    cpu_req_in && !cpu_write_in && cpu_hit |=> cpu_to_dram_out == $past(cpu_attr[`FLD_RD]))
    else $error("cpu read routed against its read bit");

  wr_route_a: assert property ( // [R05]
    cpu_req_in && cpu_write_in && cpu_hit |=> cpu_to_pci_out == !$past(cpu_attr[`FLD_WR]))
    else $error("cpu write routed against its write bit");

  one_path_a: assert property ( // [R15]
    cpu_in_range_out |-> (cpu_to_dram_out ^ cpu_to_pci_out))
    else $error("in-range cycle needs exactly one destination");

  outside_a: assert property ( // [R21]
    cpu_req_in && !cpu_hit |=> cpu_valid_out && !cpu_to_dram_out && !cpu_to_pci_out)
    else $error("out-of-range cycle was routed");

  l1_code_a: assert property ( // [R08]
    cpu_l1_cacheable_out && cpu_state_out == seg_read_only |-> $past(cpu_code_in))
    else $error("read-only segment cached on a data read");

  l2_ro_a: assert property ( // [R11]
    cpu_l2_alloc_out |-> cpu_state_out == seg_read_write && cpu_to_dram_out)
    else $error("second-level allocation outside read/write");

  pci_claim_a: assert property ( // [R17]
    pci_claim_out |-> $past(pci_hit) &&
      $past(pci_write_in ? pci_attr[`FLD_WR] : pci_attr[`FLD_RD]))
    else $error("pci cycle claimed without permission");

  bresp_time_a: assert property ( // [R02]
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##[1:2] bvalid_out)
    else $error("write response late");

  wr_takes_a: assert property ( // [R02]
    aw_held && w_held && !bvalid_out && w_lane && reg_index(aw_addr) == 3'h1
      |=> attribute_map[1] == ($past(w_byte) & `ATTR_MASK))
    else $error("attribute write not stored");

  rd_cov_c: cover property (cpu_valid_out && cpu_to_dram_out && cpu_state_out == seg_read_only);
  shadow_cov_c: cover property (cpu_to_dram_out && cpu_state_out == seg_write_only);
  claim_cov_c: cover property (pci_claim_out);
  l1_cov_c: cover property (cpu_l1_cacheable_out);

endmodule : legacy_segment_attribute_router

// File: tb/lookup_source.sv
// cpu cycle decoder and pci master model issuing attribute lookups
`timescale 1ns/100ps

module lookup_source (
  input  wire logic clk_in,
  output logic      cpu_req_out,
  output logic      [31:0] cpu_addr_out,
  output logic      cpu_write_out,
  output logic      cpu_code_out,
  output logic      pci_req_out,
  output logic      [31:0] pci_addr_out,
  output logic      pci_write_out
);
  // ************************************************
  // request driver
  // ************************************************
  initial begin
    {cpu_req_out, cpu_write_out, cpu_code_out, pci_req_out, pci_write_out} = 5'h00;
    cpu_addr_out = 32'h0;
    pci_addr_out = 32'h0;
  end

  // cpu and pci ask about the same address in the same cycle
  task automatic issue(input logic [31:0] a, input logic w, input logic c);
    @(posedge clk_in);
    cpu_req_out   <= 1'b1;
    cpu_addr_out  <= a;
    cpu_write_out <= w;
    cpu_code_out  <= c;
    pci_req_out   <= 1'b1;
    pci_addr_out  <= a;
    pci_write_out <= w;
    @(posedge clk_in);
    // idle qualifiers flip so a stale value cannot pass for a live one
    cpu_req_out   <= 1'b0;
    pci_req_out   <= 1'b0;
    cpu_addr_out  <= ~a;
    pci_addr_out  <= ~a;
    cpu_write_out <= ~w;
    cpu_code_out  <= ~c;
    pci_write_out <= ~w;
  endtask : issue
endmodule : lookup_source

// File: tb/testbench.sv
// self-checking bench for the legacy segment attribute router
`timescale 1ns/100ps

module testbench;
  import segment_attr_pkg::*;
  // ************************************************
  // signals and instances
  // ************************************************
  logic        clk_in = 1'b0, reset_n_in = 1'b0;
  logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic        arvalid_in = 1'b0, rready_in = 1'b0;
  logic [11:0] awaddr_in = 12'h0, araddr_in = 12'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out, cpu_addr_in, pci_addr_in;
  logic [3:0]  wstrb_in = 4'h0;
  logic [1:0]  bresp_out, rresp_out;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic        cpu_req_in, cpu_write_in, cpu_code_in, pci_req_in, pci_write_in;
  logic        cpu_valid_out, cpu_in_range_out, cpu_to_dram_out, cpu_to_pci_out;
  logic        cpu_l1_cacheable_out, cpu_l2_alloc_out, pci_valid_out, pci_claim_out;
  seg_state_t  cpu_state_out;
  int          n_mismatch = 0, cmp_count = 0;

  legacy_segment_attribute_router dut_u (
    .clk_in, .reset_n_in, .awvalid_in, .awaddr_in, .awready_out, .wvalid_in, .wdata_in,
    .wstrb_in, .wready_out, .bvalid_out, .bresp_out, .bready_in, .arvalid_in, .araddr_in,
    .arready_out, .rvalid_out, .rdata_out, .rresp_out, .rready_in, .cpu_req_in, .cpu_addr_in,
    .cpu_write_in, .cpu_code_in, .cpu_valid_out, .cpu_in_range_out, .cpu_to_dram_out,
    .cpu_to_pci_out, .cpu_l1_cacheable_out, .cpu_l2_alloc_out, .cpu_state_out, .pci_req_in,
    .pci_addr_in, .pci_write_in, .pci_valid_out, .pci_claim_out);

  lookup_source partner_u (
    .clk_in, .cpu_req_out(cpu_req_in), .cpu_addr_out(cpu_addr_in),
    .cpu_write_out(cpu_write_in), .cpu_code_out(cpu_code_in), .pci_req_out(pci_req_in),
    .pci_addr_out(pci_addr_in), .pci_write_out(pci_write_in));

  always #2.5 clk_in = ~clk_in;

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // handshakes are judged at the rising edge, where the slave samples them too
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    awvalid_in <= 1'b1;
    awaddr_in  <= a;
    wvalid_in  <= 1'b1;
    wdata_in   <= {24'h0, d};
    wstrb_in   <= 4'h1;
    bready_in  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
      if (bvalid_out) begin
        done = 1'b1;
        r    = bresp_out;
        bready_in <= 1'b0;
      end
    end
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    arvalid_in <= 1'b1;
    araddr_in  <= a;
    rready_in  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      if (rvalid_out) begin
        done = 1'b1;
        d    = rdata_out;
        r    = rresp_out;
        rready_in <= 1'b0;
      end
    end
  endtask : axr

  // k is the attribute nibble in force: bit0 read, bit1 write, bit2 cache
  task automatic look(input logic [31:0] a, input logic w, input logic c, input logic [3:0] k,
                      input logic in_r);
    logic rd, wr, ce, go;
    rd = k[0] & in_r;
    wr = k[1] & in_r;
    ce = k[2] & in_r;
    go = w ? wr : rd;
    partner_u.issue(a, w, c);
    #1;
    chk(cpu_valid_out, 1'b1);
    chk(cpu_in_range_out, in_r);
    chk(cpu_to_dram_out, go);
    chk(cpu_to_pci_out, in_r & ~go);
    chk(cpu_state_out, {wr, rd});
    chk(cpu_l1_cacheable_out, ~w & ce & rd & (wr | c));
    chk(cpu_l2_alloc_out, rd & wr);
    chk(pci_valid_out, 1'b1);
    chk(pci_claim_out, go);
  endtask : look

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      axr(12'(12'h164 + 4 * i), d, r);
      chk(d, 32'h0);
      chk(r, 2'b00);
    end
    look(32'h000f0000, 1'b0, 1'b1, 4'h0, 1'b1);
    look(32'h000c0000, 1'b1, 1'b0, 4'h0, 1'b1);
  endtask : t_reset

  task automatic t_mask;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      axw(12'(12'h164 + 4 * i), 8'hff, r);
      chk(r, 2'b00);
      axr(12'(12'h164 + 4 * i), d, r);
      chk(d, (i == 0) ? 32'h70 : 32'h77);
    end
    axr(12'h180, d, r);
    chk({d, r}, {32'h0, 2'b10});
    axw(12'h160, 8'h55, r);
    chk(r, 2'b10);
  endtask : t_mask

  task automatic t_routes;
    // software never sets cache without read enable
    logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h5, 4'h2, 4'h3, 4'h7};
    logic [31:0] lo, hi;
    logic [1:0]  r;
    for (int f = 1; f < 14; f++) begin
      lo = (f == 1) ? 32'h000f0000 : 32'(32'h000c0000 + 32'h4000 * (f - 2));
      hi = lo + ((f == 1) ? 32'hfffc : 32'h3ffc);
      foreach (codes[j]) begin
        axw(12'(12'h164 + 4 * (f / 2)),
            (f % 2) ? {codes[j], 4'h0} : {4'h0, codes[j]}, r);
        look(lo, 1'b0, 1'b0, codes[j], 1'b1);
        look(hi, 1'b0, 1'b1, codes[j], 1'b1);
        look(lo, 1'b1, 1'b0, codes[j], 1'b1);
      end
    end
  endtask : t_routes

  task automatic t_outside;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) axw(12'(12'h164 + 4 * i), 8'h77, r);
    look(32'h000bfffc, 1'b0, 1'b1, 4'h7, 1'b0);
    look(32'h000a0000, 1'b1, 1'b0, 4'h7, 1'b0);
    look(32'h00100000, 1'b0, 1'b0, 4'h7, 1'b0);
    look(32'h000c0000, 1'b0, 1'b0, 4'h7, 1'b1);
  endtask : t_outside

  // a reset in mid-run must clear attributes that software had set
  task automatic t_rereset;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    axr(12'h17c, d, r);
    chk({d, r}, {32'h0, 2'b00});
    look(32'h000ec000, 1'b0, 1'b1, 4'h0, 1'b1);
    look(32'h000f0000, 1'b1, 1'b0, 4'h0, 1'b1);
  endtask : t_rereset

  // ************************************************
  // run control
  // ************************************************
  task automatic wrap_up;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_mask();
    t_routes();
    t_outside();
    t_rereset();
    wrap_up();
  end

  // the full run needs about a thousand cycles; this leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule : testbench
